// ==== async_sram_128kx8_port_tb_top.sv ====
/*
  self-checking bench for the memory host controller.
  assumes the behavioural memory model stands on the far side.
*/
`timescale 1ns/1ps
module async_sram_128kx8_port_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic retain_req = 1'b0;
  sram_host_pkg::mem_req_t req = '0;
  logic req_ready, rdata_valid, retained, oe_n, dev_en;
  logic [7:0] rdata, lanes_out, dev_q;
  logic [7:0] last = 8'h00;
  logic [16:0] addr;
  wire logic [7:0] lanes;
  sram_host_pkg::mem_ctl_t ctl;
  int err_count = 0;
  int comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  // no pull on the lanes: a floating lane shows the inverse of its last level
  assign #2 lanes = !oe_n ? lanes_out : dev_en ? dev_q : ~last;
  always @(posedge sys_clk) if (!oe_n || dev_en) last <= lanes;
  sram_host DUT (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .retain_req(retain_req), .req_ready(req_ready), .rdata_valid(rdata_valid),
    .rdata(rdata), .retained(retained), .word_index_lines(addr),
    .byte_lanes_out(lanes_out), .byte_lanes_oe_n(oe_n), .byte_lanes_in(lanes), .ctl(ctl));
  sram_dev_model u_mem (.word_index_lines(addr), .byte_lanes(lanes), .ctl(ctl),
    .drive_q(dev_q), .drive_en(dev_en));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (req_ready !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t controller never became ready", $time);
    end
    req_valid = 1'b1;
    req = '{wr, a, d};
    @(posedge sys_clk);
    #1 req_valid = 1'b0;
    @(posedge sys_clk);
    #1 if (wr) check({7'h0, dev_en}, 8'h00);
    n = 0;
    while (!wr && rdata_valid !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (!wr && rdata_valid !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t no read data pulse", $time);
    end
    if (!wr) check(rdata, d);
  endtask : access
  task automatic t_powerup;
    repeat (2)
    begin
      @(posedge sys_clk);
      #1 check({7'h0, req_ready}, 8'h00);
    end
  endtask : t_powerup
  task automatic t_wr_rd;
    access(1'b1, 17'h00000, 8'hA5);
    access(1'b1, 17'h1FFFF, 8'h5A);
    access(1'b1, 17'h0AAAA, 8'h3C);
    access(1'b0, 17'h00000, 8'hA5);
    access(1'b0, 17'h1FFFF, 8'h5A);
    access(1'b1, 17'h00000, 8'hC3);
    access(1'b0, 17'h00000, 8'hC3);
    access(1'b0, 17'h0AAAA, 8'h3C);
  endtask : t_wr_rd
  task automatic t_retain;
    retain_req = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 check({7'h0, retained}, 8'h01);
    check({6'h0, ctl.sel_n | ~ctl.sel, dev_en}, 8'h02);
    check({7'h0, req_ready}, 8'h00);
    retain_req = 1'b0;
    access(1'b0, 17'h1FFFF, 8'h5A);
  endtask : t_retain
  task automatic t_reset;
    nrst = 1'b0;
    #1 check({6'h0, ctl.sel_n, ctl.sel}, 8'h02);
    check({7'h0, oe_n}, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    t_powerup();
    access(1'b0, 17'h00000, 8'hC3);
  endtask : t_reset
  task automatic results;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    #100000 err_count++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    t_powerup();
    t_wr_rd();
    t_retain();
    t_reset();
    results();
  end
endmodule : async_sram_128kx8_port_tb_top

// ==== sram_dev_model.sv ====
/*
  behavioural 128K x 8 asynchronous memory.
  assumes the lanes are resolved outside from drive_en and drive_q.
*/
`timescale 1ns/1ps
module sram_dev_model #(
  parameter int ACC_NS = 40
) (
  input wire logic [16:0] word_index_lines, // address pins
  input wire logic [7:0] byte_lanes, // resolved lanes
  input wire sram_host_pkg::mem_ctl_t ctl, // control pins
  output logic [7:0] drive_q, // value put on lanes
  output logic drive_en // high while memory drives lanes
);
  logic [7:0] mem [0:131071];
  wire logic sel_ok = !ctl.sel_n && ctl.sel;
  wire logic wr = sel_ok && !ctl.strobe_n;
  // turn-on and turn-off both 10 ns: late enough to start, early enough to float
  assign #10 drive_en = sel_ok && ctl.strobe_n && !ctl.gate_n;
  // slow answer, still inside the access time
  assign #(ACC_NS) drive_q = mem[word_index_lines];
  always @(negedge wr) mem[word_index_lines] <= byte_lanes;
endmodule : sram_dev_model

// ==== sram_host.sv ====
/*
  host controller driving a 128K x 8 asynchronous static memory over its pins.
  assumes lanes are resolved by the testbench from byte_lanes_oe_n; requests are
  synchronous to sys_clk; memory read data settles within the access count.
*/
`timescale 1ns/1ps
module sram_host #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W,
  parameter int DATA_W = sram_host_pkg::DATA_W
) (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic nrst, // async reset, active low
  input wire logic req_valid, // request present
  input wire sram_host_pkg::mem_req_t req, // request contents
  input wire logic retain_req, // level: hold memory in retention
  output logic req_ready, // controller can take a request
  output logic rdata_valid, // one-cycle pulse with read byte
  output logic [DATA_W-1:0] rdata, // read byte
  output logic retained, // memory is deselected for retention
  output logic [ADDR_W-1:0] word_index_lines, // address pins
  output logic [DATA_W-1:0] byte_lanes_out, // data lanes, driven value
  output logic byte_lanes_oe_n, // low while host drives lanes
  input wire logic [DATA_W-1:0] byte_lanes_in, // data lanes, sensed value
  output sram_host_pkg::mem_ctl_t ctl // select, strobe and gate pins
);
  localparam int CNT_MAX = (1 << sram_host_pkg::CNT_W) - 1;

  // the pin widths are those of the one memory this controller serves
  if (ADDR_W != sram_host_pkg::ADDR_W || DATA_W != sram_host_pkg::DATA_W)
  begin : g_bad_width
    $error("sram_host: memory is fixed at 17 address and 8 data bits");
  end
  // every timing count must fit the down-counter; a write pulse needs at least one cycle
  if (sram_host_pkg::POWERUP_CYC > CNT_MAX || sram_host_pkg::ACCESS_CYC > CNT_MAX ||
      sram_host_pkg::RCYC_CYC > CNT_MAX || sram_host_pkg::FLOAT_CYC > CNT_MAX ||
      sram_host_pkg::WCYC_CYC > CNT_MAX || sram_host_pkg::PULSE_CYC < 1 ||
      sram_host_pkg::WCYC_CYC < sram_host_pkg::PULSE_CYC)
  begin : g_bad_count
    $error("sram_host: timing counts do not fit the cycle counter");
  end

  localparam logic [3:0] PULSE_C = 4'(sram_host_pkg::PULSE_CYC);
  localparam logic [3:0] WCYC_C = 4'(sram_host_pkg::WCYC_CYC);
  localparam logic [3:0] ACCESS_C = 4'(sram_host_pkg::ACCESS_CYC);
  localparam logic [3:0] RCYC_C = 4'(sram_host_pkg::RCYC_CYC);
  localparam logic [3:0] FLOAT_C = 4'(sram_host_pkg::FLOAT_CYC);
  localparam logic [3:0] PWR_C = 4'(sram_host_pkg::POWERUP_CYC);
  localparam logic [3:0] ONE = 4'h1;
  // idle keeps the memory selected with strobe and gate high, so its outputs float
  localparam sram_host_pkg::mem_ctl_t CTL_IDLE = '{sel_n: 1'b0, sel: 1'b1, strobe_n: 1'b1,
    gate_n: 1'b1};
  // either select off would do; both are dropped so one stuck pin cannot wake the memory
  localparam sram_host_pkg::mem_ctl_t CTL_OFF = '{sel_n: 1'b1, sel: 1'b0, strobe_n: 1'b1,
    gate_n: 1'b1};

  sram_host_pkg::host_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic req_ready_reg, req_ready_next;
  logic rdata_valid_reg, rdata_valid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic retained_reg, retained_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic oe_n_reg, oe_n_next;
  sram_host_pkg::mem_ctl_t ctl_reg, ctl_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    req_ready_next = 1'b0;
    rdata_valid_next = 1'b0;
    rdata_next = rdata_reg;
    retained_next = retained_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    oe_n_next = 1'b1;
    ctl_next = ctl_reg;
    case (state_reg)
      sram_host_pkg::ST_POWERUP:
      begin
        // memory stays deselected until the supply has settled
        ctl_next = CTL_OFF;
        if (cnt_reg == ONE)
        begin
          state_next = sram_host_pkg::ST_IDLE;
          ctl_next = CTL_IDLE;
          req_ready_next = !retain_req;
        end
        else
          cnt_next = cnt_reg - ONE;
      end
      sram_host_pkg::ST_IDLE:
      begin
        ctl_next = CTL_IDLE;
        // a request already shown ready is honoured before retention is entered
        if (req_valid && req_ready_reg)
        begin
          // address and data change only here, on the same edge on which strobe or gate falls
          addr_next = req.addr;
          wdata_next = req.wdata;
          if (req.write)
          begin
            ctl_next.strobe_n = 1'b0;
            oe_n_next = 1'b0;
            cnt_next = PULSE_C;
            state_next = sram_host_pkg::ST_WRITE;
          end
          else
          begin
            ctl_next.gate_n = 1'b0;
            cnt_next = ACCESS_C;
            state_next = sram_host_pkg::ST_READ;
          end
        end
        else if (retain_req)
        begin
          // deselect first; zero margin is met by flagging one cycle later
          ctl_next = CTL_OFF;
          state_next = sram_host_pkg::ST_RETAIN;
        end
        else
          req_ready_next = 1'b1;
      end
      sram_host_pkg::ST_WRITE:
      begin
        // gate stays high the whole write so the memory never drives
        oe_n_next = 1'b0;
        if (cnt_reg == ONE)
        begin
          // strobe rises; data and address stay until after the edge
          ctl_next.strobe_n = 1'b1;
          cnt_next = WCYC_C - PULSE_C;
          state_next = sram_host_pkg::ST_RECOVER;
        end
        else
          cnt_next = cnt_reg - ONE;
      end
      sram_host_pkg::ST_READ:
      begin
        // gate stays low for the whole access count, then the lanes are sampled once
        if (cnt_reg == ONE)
        begin
          rdata_next = byte_lanes_in;
          rdata_valid_next = 1'b1;
          ctl_next.gate_n = 1'b1;
          cnt_next = FLOAT_C;
          state_next = sram_host_pkg::ST_RECOVER;
        end
        else
          cnt_next = cnt_reg - ONE;
      end
      sram_host_pkg::ST_RECOVER:
      begin
        // lanes released one cycle after the strobe rose; bus turns round here
        if (cnt_reg <= ONE)
        begin
          state_next = sram_host_pkg::ST_IDLE;
          req_ready_next = !retain_req;
        end
        else
          cnt_next = cnt_reg - ONE;
      end
      sram_host_pkg::ST_RETAIN:
      begin
        ctl_next = CTL_OFF;
        retained_next = retain_req;
        if (!retain_req)
        begin
          ctl_next = CTL_IDLE;
          // one full read cycle passes before the next access may start
          cnt_next = RCYC_C;
          state_next = sram_host_pkg::ST_RECOVER;
        end
      end
      default:
      begin
        state_next = sram_host_pkg::ST_POWERUP;
        cnt_next = PWR_C;
        ctl_next = CTL_OFF;
      end
    endcase
  end

  // registers only; every decision is taken in the next-state process
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= sram_host_pkg::ST_POWERUP;
      cnt_reg <= PWR_C;
      req_ready_reg <= 1'b0;
      rdata_valid_reg <= 1'b0;
      rdata_reg <= '0;
      retained_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      oe_n_reg <= 1'b1;
      ctl_reg <= CTL_OFF;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      req_ready_reg <= req_ready_next;
      rdata_valid_reg <= rdata_valid_next;
      rdata_reg <= rdata_next;
      retained_reg <= retained_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      oe_n_reg <= oe_n_next;
      ctl_reg <= ctl_next;
    end
  end

  // every pin comes straight from a flip-flop, so no glitch reaches the memory
  assign req_ready = req_ready_reg;
  assign rdata_valid = rdata_valid_reg;
  assign rdata = rdata_reg;
  assign retained = retained_reg;
  assign word_index_lines = addr_reg;
  assign byte_lanes_out = wdata_reg;
  assign byte_lanes_oe_n = oe_n_reg;
  assign ctl = ctl_reg;
endmodule : sram_host

// ==== sram_host_pkg.sv ====
/*
  constants and carriers for the static memory host controller.
  assumes a 40 MHz system clock and an asynchronous 128K x 8 memory on the far side.
*/
// What this block does
// - write happens only while both selects and strobe are asserted
// - write data stable 25 ns before and 0 ns after write end
// - address before strobe falls, 35 ns to end, 35 ns pulse, 45 ns cycle; the address is registered on the same edge as strobe falls
// - address held unchanged until write ends, 0 ns hold minimum
// - deselect before retention; wait one read cycle before resuming
// - wait over 45 ns after power-up before any access
package sram_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 40;
  localparam int CLK_PS = 1000000 / CLK_MHZ;
  localparam int DATA_SETUP_NS = 25;
  localparam int ADDR_TO_END_NS = 35;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_CYCLE_NS = 45;
  localparam int ADDR_ACCESS_NS = 45;
  localparam int GATE_ACCESS_NS = 20;
  localparam int READ_CYCLE_NS = 45;
  localparam int GATE_FLOAT_NS = 15;
  localparam int SELECT_FLOAT_NS = 20;
  localparam int POWERUP_NS = 45;
  // least times round up to whole cycles
  localparam int PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WCYC_CYC = (WRITE_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RCYC_CYC = (READ_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FLOAT_CYC = (SELECT_FLOAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // strictly more than the power-up figure, so one extra cycle
  localparam int POWERUP_CYC = (POWERUP_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic sel_n;
    logic sel;
    logic strobe_n;
    logic gate_n;
  } mem_ctl_t;

  typedef enum logic [5:0] {
    ST_POWERUP = 6'h01,
    ST_IDLE = 6'h02,
    ST_READ = 6'h04,
    ST_WRITE = 6'h08,
    ST_RECOVER = 6'h10,
    ST_RETAIN = 6'h20
  } host_state_t;
endpackage : sram_host_pkg

// ==== sram_host_props.sv ====
/*
  pin-level assertions for the memory host controller.
  assumes it is bound to every sram_host instance.
*/
`timescale 1ns/1ps
module sram_host_props #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 8
) (
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic req_valid, // request offered
  input wire logic req_ready, // controller can take a request
  input wire logic rdata_valid, // read pulse
  input wire logic retained, // retention level
  input wire logic [ADDR_W-1:0] word_index_lines, // address pins
  input wire logic [DATA_W-1:0] byte_lanes_out, // write data
  input wire logic byte_lanes_oe_n, // low while host drives
  input wire sram_host_pkg::mem_ctl_t ctl // control pins
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_low;
    !ctl.strobe_n [*2];
  endsequence
  sequence s_gate_low;
    !ctl.gate_n [*2] ##1 ctl.gate_n;
  endsequence
  AST_NO_FIGHT: assert property (!byte_lanes_oe_n |-> ctl.gate_n)
    else $error("host drives lanes with gate low");
  AST_WR_SEL: assert property (!ctl.strobe_n |-> !ctl.sel_n && ctl.sel)
    else $error("strobe low while deselected");
  AST_PULSE: assert property ($fell(ctl.strobe_n) |-> s_wr_low)
    else $error("write pulse too short");
  AST_DATA: assert property (!ctl.strobe_n |-> !byte_lanes_oe_n ##1 $stable(byte_lanes_out))
    else $error("write data moved during pulse");
  AST_ADDR: assert property (!ctl.strobe_n |=> $stable(word_index_lines))
    else $error("address moved during write");
  AST_GATE: assert property ($fell(ctl.gate_n) |-> s_gate_low ##0 rdata_valid)
    else $error("read gate length or data pulse wrong");
  AST_RD_SEL: assert property (!ctl.gate_n |-> !ctl.sel_n && ctl.sel && ctl.strobe_n)
    else $error("gate low outside a read");
  AST_RDV: assert property (rdata_valid |-> $rose(ctl.gate_n))
    else $error("read pulse without gate end");
  AST_RETAIN: assert property (retained |-> (ctl.sel_n || !ctl.sel) && byte_lanes_oe_n)
    else $error("memory selected in retention");
  AST_TAKE: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready held after a take");
endmodule : sram_host_props
bind sram_host sram_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
  .rdata_valid(rdata_valid), .retained(retained), .word_index_lines(word_index_lines),
  .byte_lanes_out(byte_lanes_out), .byte_lanes_oe_n(byte_lanes_oe_n), .ctl(ctl));
